/* rtl/mgtc_top.sv */
// The AHB-Lite slave port and the register offsets were chosen for this implementation.
`include "mgtc_cfg.svh"
`default_nettype none
// Summary of operation
// [R1] code 00: 4-clock refresh, 3-phase negation
// [R2] codes 01..11: 6/7/8 clocks, 5 phases
// [R3] page size code sets page compare span
// [R4] code 111 decodes as 4096 addresses
// [R5] port width picks data-size acknowledge lines
// [R6] burst master gets transfer acknowledge instead
// [R7] only 32/16-bit DRAM widths, no 8-bit
// [R8] outside: no external ack in page mode
// [R9] outside: no transfer ack in bursts
// [R10] burst precharge 4/6 phases, minus tss
// [R11] tss reduction only on back-to-back cycles
// [R12] native precharge 4/6, minus page mode
// [R13] page-hit writes get extra CAS clock
// [R14] burst writes to SRAM add wait
// [R15] strobe master SRAM wait when async
// [R16] async SRAM cycle length per table
// [R17] async: chip select follows address strobe
// [R18] async: CAS/ack negate with strobe
// [R19] sync: clocked timing, attributes honoured
// [R20] parity only when synchronous access set
// [R21] sync/timing combos; 10 forbidden
// [R22] parity type bit: 0 even, 1 odd
// [R23] refresh only while refresh enabled
module mgtc_top (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_rstn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic [31:0]               hrdata,
    input  wire logic                 i_refresh_tick,
    input  wire logic                 i_burst_master,
    input  wire logic                 i_write,
    input  wire logic                 i_dram_bank,
    input  wire logic                 i_page_hit,
    input  wire logic                 i_back_to_back,
    input  wire logic [3:0]           i_cycle_length_field,
    input  wire logic                 i_address_strobe_n,
    output mgtc_pkg::mgtc_timing_t    o_timing,
    output logic                      o_refresh_busy,
    output logic                      o_refresh_ras_n,
    output logic                      o_refresh_cas_n,
    output logic                      o_cfg_error
);
    import mgtc_pkg::*;

    // ==========================================
    // ahb-lite slave
    logic [31:0] gmem_q;
    logic [31:0] gmem_d;
    logic [31:0] modcfg_q;
    logic [31:0] modcfg_d;
    logic        wr_pend_q;
    logic [5:0]  wr_addr_q;
    logic        rd_take;
    logic [31:0] rdata_d;
    logic [31:0] status_w;

    assign rd_take = hsel && hready && htrans[1] && !hwrite && (hsize == `MGTC_HSIZE_WORD);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 6'h00;
        end else if (hready) begin
            wr_pend_q <= hsel && htrans[1] && hwrite && (hsize == `MGTC_HSIZE_WORD);
            wr_addr_q <= haddr[5:0];
        end
    end

    always_comb begin
        gmem_d   = gmem_q;
        modcfg_d = modcfg_q;
        if (wr_pend_q && wr_addr_q == `MGTC_OFS_GMEM) begin
            gmem_d = hwdata & `MGTC_GMEM_WMASK;
        end
        if (wr_pend_q && wr_addr_q == `MGTC_OFS_MODCFG) begin
            modcfg_d = hwdata & `MGTC_MODCFG_WMASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            gmem_q   <= `MGTC_GMEM_RESET;
            modcfg_q <= `MGTC_MODCFG_RESET;
        end else begin
            gmem_q   <= gmem_d;
            modcfg_q <= modcfg_d;
        end
    end

    // read sees a write finishing in the same cycle, hence the _d values
    always_comb begin
        unique case (haddr[5:0])
            `MGTC_OFS_GMEM:   rdata_d = gmem_d;
            `MGTC_OFS_MODCFG: rdata_d = modcfg_d;
            `MGTC_OFS_STATUS: rdata_d = status_w;
            default:          rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= haddr[1:0] == 2'b00 ? rdata_d : 32'h0000_0000;
            end
        end
    end

    // ==========================================
    // field views
    logic       rf_on;
    logic [1:0] rcyc;
    logic [2:0] pgs;
    logic [1:0] dps;
    logic       sync_on;
    logic       ext_master_extra_wait;
    logic       bus_timing_select;
    logic       page_mode_on;

    assign rf_on   = gmem_q[`MGTC_B_REFRESH_ON];
    assign rcyc    = gmem_q[`MGTC_F_RCYC];
    assign pgs     = gmem_q[`MGTC_F_PGS];
    assign dps     = gmem_q[`MGTC_F_DPS];
    assign sync_on = gmem_q[`MGTC_B_SYNC];
    assign ext_master_extra_wait    = gmem_q[`MGTC_B_EXT_MASTER_EXTRA_WAIT];
    assign bus_timing_select    = modcfg_q[`MGTC_B_BUS_TIMING_SELECT];
    assign page_mode_on    = modcfg_q[`MGTC_B_PAGE_MODE_ON];

    // ==========================================
    // address strobe synchroniser
    logic as_meta_q;
    logic as_sync_q;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            as_meta_q <= 1'b1;
            as_sync_q <= 1'b1;
        end else begin
            as_meta_q <= i_address_strobe_n;
            as_sync_q <= as_meta_q;
        end
    end

    // ==========================================
    // refresh sequencer
    mgtc_rf_state_t rf_state_q;
    logic           rf_pend_q;
    logic [3:0]     rf_cnt_q;
    logic [3:0]     rf_len_q;
    logic [3:0]     rf_neg_q;
    logic [3:0]     len_sel;
    logic [3:0]     neg_sel;
    logic           rf_start;
    logic           rf_last;

    always_comb begin
        unique case (rcyc)
            2'b00: len_sel = `MGTC_RF_LEN0; // [R1]
            2'b01: len_sel = `MGTC_RF_LEN1; // [R2]
            2'b10: len_sel = `MGTC_RF_LEN2; // [R2]
            2'b11: len_sel = `MGTC_RF_LEN3; // [R2]
        endcase
        neg_sel = (rcyc == 2'b00) ? `MGTC_RF_NEG0 : `MGTC_RF_NEGN; // [R1] [R2]
    end

    assign rf_start = (rf_state_q == MGTC_RF_IDLE) && rf_pend_q && rf_on; // [R23]
    assign rf_last  = (rf_state_q == MGTC_RF_RUN) && (rf_cnt_q == rf_len_q - 4'd1);

    // a tick landing with the start is kept, set beats clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rf_pend_q <= 1'b0;
        end else if (i_refresh_tick) begin
            rf_pend_q <= 1'b1;
        end else if (rf_start) begin
            rf_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rf_state_q <= MGTC_RF_IDLE;
            rf_cnt_q   <= 4'd0;
            rf_len_q   <= `MGTC_RF_LEN0;
            rf_neg_q   <= `MGTC_RF_NEG0;
        end else begin
            unique case (rf_state_q)
                MGTC_RF_IDLE: begin
                    rf_cnt_q <= 4'd0;
                    if (rf_start) begin
                        rf_state_q <= MGTC_RF_RUN;
                        rf_len_q   <= len_sel;
                        rf_neg_q   <= neg_sel;
                    end
                end
                MGTC_RF_RUN: begin
                    rf_cnt_q <= rf_cnt_q + 4'd1;
                    if (rf_last) begin
                        rf_state_q <= MGTC_RF_IDLE;
                    end
                end
            endcase
        end
    end

    // phases are half clocks; ras waits the rounded-up whole clocks
    logic [3:0] neg_clks;
    assign neg_clks = (rf_neg_q + 4'd1) >> 1;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_refresh_busy  <= 1'b0;
            o_refresh_ras_n <= 1'b1;
            o_refresh_cas_n <= 1'b1;
        end else begin
            // busy spans every run clock, last one included
            o_refresh_busy  <= (rf_state_q == MGTC_RF_RUN);
            o_refresh_cas_n <= !(rf_state_q == MGTC_RF_RUN);
            o_refresh_ras_n <= !((rf_state_q == MGTC_RF_RUN)
                                 && (rf_cnt_q >= neg_clks)); // [R1] [R2]
        end
    end

    // ==========================================
    // timing decode
    mgtc_timing_t tm_d;
    logic [2:0]   pre_b;
    logic [2:0]   pre_n;

    always_comb begin
        unique case (pgs)
            3'b000:        tm_d.page_lsb = `MGTC_PG_256; // [R3]
            3'b001, 3'b010: tm_d.page_lsb = `MGTC_PG_512; // [R3]
            3'b011, 3'b100: tm_d.page_lsb = `MGTC_PG_1K;  // [R3]
            3'b101, 3'b110: tm_d.page_lsb = `MGTC_PG_2K;  // [R3]
            3'b111:        tm_d.page_lsb = `MGTC_PG_4K;  // [R4]
        endcase
        // no code selects 8 bits; reserved negates both ack lines like external but gets no external ack path
        tm_d.port_width = mgtc_width_t'(dps); // [R7]
        unique case (dps)
            2'b00:   tm_d.data_size_ack_n = 2'b00; // [R5]
            2'b01:   tm_d.data_size_ack_n = 2'b01; // [R5]
            default: tm_d.data_size_ack_n = 2'b11; // [R5]
        endcase
        tm_d.use_transfer_ack = i_burst_master && !dps[1]; // [R6]
        // page mode banks never get the external ack path
        tm_d.ext_ack_allowed  = (dps == 2'b11) && !page_mode_on; // [R8] [R9]
        pre_b = gmem_q[`MGTC_B_WBTB] ? `MGTC_PRE_LONG : `MGTC_PRE_SHORT; // [R10]
        if (gmem_q[`MGTC_B_TSS] && i_back_to_back) begin
            pre_b = pre_b - 3'd1; // [R11]
        end
        pre_n = gmem_q[`MGTC_B_WBTN] ? `MGTC_PRE_LONG : `MGTC_PRE_SHORT; // [R12]
        if (page_mode_on) begin
            pre_n = pre_n - 3'd1; // [R12]
        end
        tm_d.ras_neg_phases = i_burst_master ? pre_b : pre_n;
        tm_d.cas_extra_clk  = !i_burst_master && gmem_q[`MGTC_B_DWN] && i_write
                              && i_dram_bank && i_page_hit
                              && (i_cycle_length_field == `MGTC_CYCLE_LENGTH_FIELD_PGWR); // [R13]
        tm_d.sram_extra_wait = i_burst_master
            ? (gmem_q[`MGTC_B_DWB] && i_write && !i_dram_bank) // [R14]
            : (ext_master_extra_wait && !sync_on && !i_dram_bank); // [R15]
        if (i_cycle_length_field <= 4'd1 && !(ext_master_extra_wait && i_cycle_length_field == 4'd1)) begin
            tm_d.sram_cycle_clks = `MGTC_SRAM_MIN; // [R16]
        end else begin
            tm_d.sram_cycle_clks = {1'b0, i_cycle_length_field} + `MGTC_SRAM_ADD
                                   + {4'd0, ext_master_extra_wait} + {4'd0, !bus_timing_select}; // [R16]
        end
        tm_d.cs_follow_strobe = !sync_on; // [R17]
        tm_d.attr_honoured    = sync_on && bus_timing_select; // [R19] [R21]
        tm_d.early_release    = !sync_on && as_sync_q; // [R18]
        tm_d.parity_en        = sync_on && bus_timing_select; // [R20] [R21]
        tm_d.parity_odd       = gmem_q[`MGTC_B_PARITY_TYPE_ODD]; // [R22]
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_timing    <= '0;
            o_cfg_error <= 1'b0;
        end else begin
            o_timing    <= tm_d;
            o_cfg_error <= (sync_on && !bus_timing_select) || (dps == 2'b10); // [R21] [R7]
        end
    end

    assign status_w = {28'h0000_000, rf_pend_q, o_refresh_busy,
                       dps == 2'b10, sync_on && !bus_timing_select};

    // ==========================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    sequence rf_begin(logic [3:0] len);
        $rose(o_refresh_busy) && rf_len_q == len;
    endsequence

    rf_len_four_a: assert property ( // [R1]
        rf_begin(`MGTC_RF_LEN0) |-> o_refresh_busy[*4] ##1 !o_refresh_busy)
        else $error("refresh length code 00 not 4 clocks");
    rf_len_six_a: assert property ( // [R2]
        rf_begin(`MGTC_RF_LEN1) |-> o_refresh_busy[*6] ##1 !o_refresh_busy)
        else $error("refresh length code 01 not 6 clocks");
    rf_ras_wait_a: assert property ( // [R1]
        rf_begin(`MGTC_RF_LEN0) |-> o_refresh_ras_n[*2] ##1 !o_refresh_ras_n)
        else $error("refresh ras negation wrong");
    rf_enable_gate_a: assert property ($rose(o_refresh_busy) |-> $past(rf_on, 2)) // [R23]
        else $error("refresh ran while disabled");
    page_4k_a: assert property (pgs == 3'b111 |=> o_timing.page_lsb == `MGTC_PG_4K) // [R4]
        else $error("page code 111 not 4096");
    ack_burst_a: assert property (i_burst_master && dps == 2'b01 |=> o_timing.use_transfer_ack) // [R6]
        else $error("burst master did not get transfer ack");
    sram_len_max_a: assert property ( // [R16]
        i_cycle_length_field == 4'hf && bus_timing_select && !ext_master_extra_wait |=> o_timing.sram_cycle_clks == 5'd17)
        else $error("sram cycle at cycle_length_field 15 wrong");
    parity_sync_a: assert property (!sync_on |=> !o_timing.parity_en) // [R20]
        else $error("parity offered while asynchronous");
    pre_native_a: assert property ( // [R12]
        !i_burst_master && !gmem_q[`MGTC_B_WBTN] && page_mode_on
        |=> o_timing.ras_neg_phases == 3'd3)
        else $error("native precharge with page mode wrong");

endmodule // mgtc_top
`default_nettype wire

/* rtl/mgtc_cfg.svh */
`ifndef MGTC_CFG_SVH
`define MGTC_CFG_SVH
// ==========================================
// register map
`define MGTC_OFS_GMEM      6'h00
`define MGTC_OFS_MODCFG    6'h04
`define MGTC_OFS_STATUS    6'h08
`define MGTC_GMEM_RESET    32'h0000_1200
`define MGTC_GMEM_WMASK    32'hffff_ffe0
`define MGTC_MODCFG_RESET  32'h0000_0000
`define MGTC_MODCFG_WMASK  32'h0000_0003
// ==========================================
// global memory config fields
`define MGTC_B_REFRESH_ON        23
`define MGTC_F_RCYC        22:21
`define MGTC_F_PGS         20:18
`define MGTC_F_DPS         17:16
`define MGTC_B_WBTB        15
`define MGTC_B_WBTN        14
`define MGTC_B_SYNC        13
`define MGTC_B_EXT_MASTER_EXTRA_WAIT        12
`define MGTC_B_PARITY_TYPE_ODD        11
`define MGTC_B_TSS         9
`define MGTC_B_DWN         7
`define MGTC_B_DWB         6
// module config fields
`define MGTC_B_BUS_TIMING_SELECT        0
`define MGTC_B_PAGE_MODE_ON        1
// ==========================================
// refresh lengths in clocks, ras negation in phases
`define MGTC_RF_LEN0       4'd4
`define MGTC_RF_LEN1       4'd6
`define MGTC_RF_LEN2       4'd7
`define MGTC_RF_LEN3       4'd8
`define MGTC_RF_NEG0       4'd3
`define MGTC_RF_NEGN       4'd5
// precharge phases
`define MGTC_PRE_SHORT     3'd4
`define MGTC_PRE_LONG      3'd6
// page compare lowest address bit per page size
`define MGTC_PG_256        4'd8
`define MGTC_PG_512        4'd9
`define MGTC_PG_1K         4'd10
`define MGTC_PG_2K         4'd11
`define MGTC_PG_4K         4'd12
// async sram cycle length
`define MGTC_SRAM_MIN      5'd3
`define MGTC_SRAM_ADD      5'd2
`define MGTC_CYCLE_LENGTH_FIELD_PGWR     4'h1
`define MGTC_HSIZE_WORD    3'h2
`endif

/* rtl/mgtc_pkg.sv */
`default_nettype none
package mgtc_pkg;
    typedef enum logic [1:0] {MGTC_W32, MGTC_W16, MGTC_WRSV, MGTC_WEXT} mgtc_width_t;
    typedef enum logic {MGTC_RF_IDLE, MGTC_RF_RUN} mgtc_rf_state_t;
    typedef struct packed {
        logic [2:0]  ras_neg_phases;
        logic [3:0]  page_lsb;
        mgtc_width_t port_width;
        logic [1:0]  data_size_ack_n;
        logic        use_transfer_ack;
        logic        ext_ack_allowed;
        logic        cas_extra_clk;
        logic        sram_extra_wait;
        logic [4:0]  sram_cycle_clks;
        logic        cs_follow_strobe;
        logic        attr_honoured;
        logic        early_release;
        logic        parity_en;
        logic        parity_odd;
    } mgtc_timing_t;
endpackage
`default_nettype wire

/* testbench/mgtc_partner.sv */
`default_nettype none
// ==========================================
// far side: strobe-type or burst master plus addressed bank
module mgtc_partner (
    input  wire logic       i_clk_sys,
    output var  logic       o_address_strobe_n,
    output var  logic       o_burst_master,
    output var  logic       o_write,
    output var  logic       o_dram_bank,
    output var  logic       o_page_hit,
    output var  logic       o_back_to_back,
    output var  logic [3:0] o_cycle_length_field
);
    timeunit 1ns;
    timeprecision 1ns;
    // no acknowledge lines driven: cycles end only when finish releases the strobe
    initial begin
        o_address_strobe_n = 1'b1;
        o_burst_master     = 1'b0;
        o_write            = 1'b0;
        o_dram_bank        = 1'b0;
        o_page_hit         = 1'b0;
        o_back_to_back     = 1'b0;
        o_cycle_length_field             = 4'h0;
    end
    task automatic access(input logic bm, wr, dram, hit, b2b, input logic [3:0] tc);
        o_burst_master     <= bm;
        o_write            <= wr;
        o_dram_bank        <= dram;
        o_page_hit         <= hit;
        o_back_to_back     <= b2b;
        o_cycle_length_field             <= tc;
        o_address_strobe_n <= 1'b0;
    endtask
    // slow release: strobe held for a chosen number of clocks
    task automatic finish(input int slow);
        repeat (slow) @(posedge i_clk_sys);
        o_address_strobe_n <= 1'b1;
    endtask
endmodule // mgtc_partner
`default_nettype wire

/* testbench/mgtc_top_tb_top.sv */
`include "mgtc_cfg.svh"
`default_nettype none
module mgtc_top_tb_top;
    import mgtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {string nm; logic [31:0] exp;} mgtc_note_t;
    logic         i_clk_sys, i_rstn, hsel, hwrite, hreadyout, hresp, i_refresh_tick;
    logic [31:0]  haddr, hwdata, hrdata, gm;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic         asn, bm, wr, dram, hit, b2b, busy, ras_n, cas_n, cerr, dph;
    logic [3:0]   cycle_length_field, bcnt, rcnt;
    mgtc_timing_t tim;
    mgtc_note_t   q[$];
    int           error_cnt, samples_checked;
    int           rl[4] = '{4, 6, 7, 8};
    mgtc_top u_mgtc_top (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .i_refresh_tick(i_refresh_tick),
        .i_burst_master(bm), .i_write(wr), .i_dram_bank(dram), .i_page_hit(hit),
        .i_back_to_back(b2b), .i_cycle_length_field(cycle_length_field), .i_address_strobe_n(asn), .o_timing(tim),
        .o_refresh_busy(busy), .o_refresh_ras_n(ras_n), .o_refresh_cas_n(cas_n),
        .o_cfg_error(cerr));
    mgtc_partner u_mgtc_partner (.i_clk_sys(i_clk_sys), .o_address_strobe_n(asn),
        .o_burst_master(bm), .o_write(wr), .o_dram_bank(dram), .o_page_hit(hit),
        .o_back_to_back(b2b), .o_cycle_length_field(cycle_length_field));
    always #10 i_clk_sys = ~i_clk_sys;
    // ==========================================
    // checking
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic pop(input string nm, input logic [31:0] seen);
        mgtc_note_t n;
        if (q.size() == 0) begin
            chk({nm, " unexpected"}, seen, 32'hx);
        end else begin
            n = q.pop_front();
            chk(n.nm, seen, n.exp);
        end
    endtask
    always @(posedge i_clk_sys) begin
        if (dph) begin
            pop("hrdata", hrdata);
            chk("hresp", 32'(hresp), 32'h0);
        end
        dph = i_rstn && hsel && htrans[1] && !hwrite && hreadyout;
        if (busy === 1'b1) begin
            bcnt++;
            rcnt += 4'(ras_n === 1'b0);
            chk("cas_n", 32'(cas_n), 32'h0);
        end else if (bcnt != 0) begin
            pop("refresh", {24'h0, bcnt, rcnt});
            bcnt = 0;
            rcnt = 0;
        end
    end
    // ==========================================
    // bus master
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge i_clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge i_clk_sys); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        q.push_back('{"hrdata", e});
        bus(1'b0, a, $urandom);
    endtask
    task automatic cfg(input logic [31:0] g, input logic [31:0] m);
        bus(1'b1, 32'(`MGTC_OFS_GMEM), g);
        bus(1'b1, 32'(`MGTC_OFS_MODCFG), m);
        repeat (3) @(posedge i_clk_sys);
    endtask
    task automatic tick();
        i_refresh_tick <= 1'b1;
        @(posedge i_clk_sys);
        i_refresh_tick <= 1'b0;
    endtask
    function automatic logic [4:0] sram_len(input int tc, input logic em, input logic bs);
        if (tc == 0 || (tc == 1 && !em)) return 5'd3;
        return 5'(tc + 2 + em + !bs);
    endfunction
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge i_clk_sys);
        error_cnt++;
        close_out();
    end
    // ==========================================
    // tests
    initial begin
        {i_clk_sys, i_rstn, hwrite, i_refresh_tick, dph, bcnt, rcnt} = '0;
        {haddr, hwdata, htrans, error_cnt, samples_checked} = '0;
        hsel  = 1'b1;
        hsize = `MGTC_HSIZE_WORD;
        void'($urandom(32'h3799f3dd));
        repeat (8) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        @(posedge i_clk_sys);
        rd(32'(`MGTC_OFS_GMEM), `MGTC_GMEM_RESET);
        rd(32'(`MGTC_OFS_MODCFG), `MGTC_MODCFG_RESET);
        rd(32'h20, 32'h0);
        gm = $urandom;
        bus(1'b1, 32'(`MGTC_OFS_GMEM), gm);
        rd(32'(`MGTC_OFS_GMEM), gm & `MGTC_GMEM_WMASK);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            gm = 32'h0;
            gm[`MGTC_B_REFRESH_ON] = 1'b1;
            gm[`MGTC_F_RCYC] = 2'(c);
            cfg(gm, 32'h0);
            q.push_back('{"refresh", {24'h0, 4'(rl[c]), 4'(rl[c] - (c == 0 ? 2 : 3))}});
            tick();
            repeat (16) @(posedge i_clk_sys);
        end
        cfg(32'h0, 32'h0);
        tick();
        repeat (16) @(posedge i_clk_sys);
        chk("refresh off", 32'(busy), 32'h0);
        q.push_back('{"refresh", {24'h0, 4'd8, 4'd5}});
        cfg(32'h0070_0000 | 32'h0080_0000, 32'h0);
        repeat (16) @(posedge i_clk_sys);
        $display("test refresh done");
        for (int p = 0; p < 8; p++) begin
            cfg(32'(p) << 18, 32'h0);
            chk("page_lsb", 32'(tim.page_lsb),
                p == 0 ? 8 : p == 7 ? 12 : 8 + (p + 1) / 2);
        end
        for (int k = 0; k < 8; k++) begin
            u_mgtc_partner.access(k[2], 1'b0, 1'b1, 1'b0, 1'b0, 4'h1);
            cfg(32'(k[1:0]) << 16, 32'h0);
            chk("ack lines", 32'(tim.data_size_ack_n),
                k[1:0] == 0 ? 0 : k[1:0] == 1 ? 1 : 3);
            chk("ta select", 32'(tim.use_transfer_ack), 32'(k[2] && !k[1]));
            chk("width err", 32'(cerr), 32'(k[1:0] == 2));
        end
        u_mgtc_partner.finish(1);
        $display("test decode done");
        for (int k = 0; k < 16; k++) begin
            u_mgtc_partner.access(k[0], 1'b0, 1'b1, 1'b0, k[3], 4'h1);
            gm = 32'h0;
            gm[k[0] ? `MGTC_B_WBTB : `MGTC_B_WBTN] = k[1];
            gm[`MGTC_B_TSS] = k[0] & k[2];
            cfg(gm, 32'(!k[0] & k[2]) << 1);
            chk("ras_neg", 32'(tim.ras_neg_phases),
                (k[1] ? 6 : 4) - (k[0] ? k[2] & k[3] : k[2]));
        end
        u_mgtc_partner.access(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h1);
        cfg(32'h0000_0080, 32'h0);
        chk("cas extra", 32'(tim.cas_extra_clk), 32'h1);
        u_mgtc_partner.access(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h2);
        repeat (3) @(posedge i_clk_sys);
        chk("cas extra", 32'(tim.cas_extra_clk), 32'h0);
        u_mgtc_partner.access(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 4'h2);
        cfg(32'h0000_0040, 32'h0);
        chk("sram wait", 32'(tim.sram_extra_wait), 32'h1);
        u_mgtc_partner.finish(2);
        $display("test precharge done");
        for (int j = 0; j < 4; j++) begin
            cfg(32'(j[0]) << 12, 32'(j[1]));
            for (int t = 0; t < 16; t++) begin
                u_mgtc_partner.access(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'(t));
                repeat (3) @(posedge i_clk_sys);
                chk("sram len", 32'(tim.sram_cycle_clks), 32'(sram_len(t, j[0], j[1])));
            end
            u_mgtc_partner.finish(1);
        end
        for (int j = 0; j < 4; j++) begin
            cfg((32'(j[1]) << 13) | (32'(j[0]) << 11), 32'(j[0]));
            repeat (3) @(posedge i_clk_sys);
            chk("parity", 32'(tim.parity_en), 32'(j == 3));
            chk("attrs", 32'(tim.attr_honoured), 32'(j == 3));
            chk("odd", 32'(tim.parity_odd), 32'(j[0]));
            chk("combo err", 32'(cerr), 32'(j == 2));
            chk("cs follow", 32'(tim.cs_follow_strobe), 32'(!j[1]));
            chk("release", 32'(tim.early_release), 32'(!j[1]));
        end
        cfg(32'h0, 32'h0);
        u_mgtc_partner.access(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1);
        repeat (5) @(posedge i_clk_sys);
        chk("release", 32'(tim.early_release), 32'h0);
        u_mgtc_partner.finish(4);
        repeat (5) @(posedge i_clk_sys);
        chk("release", 32'(tim.early_release), 32'h1);
        $display("test sram and sync done");
        close_out();
    end
endmodule // mgtc_top_tb_top
`default_nettype wire
